/* File: pkg/ursel_map.vh */
// Register selection constants: slot addresses, bank keys and field positions.
// Overview of operation
// - Slot zero reads receive, writes transmit holding.
// - Slot two reads identification, writes FIFO control.
// - Line status is read only.
// - Modem status is read only.
// - Transmit FIFO free space count is read only.
// - Receive FIFO fill count is read only.
// - Baud divisor held as two byte registers.
// - Divisor bytes reachable only while divisor-latch bit set.
// - Enhanced and flow characters only when line_control 0xBF.
// - Transmission control, trigger level need enhanced and modem bit2.
// - Prescaler bit changes only while enhanced bit set.
// - Bit 0 meanings per register decoded.
// - Bit 1 meanings per register decoded.
// - Bit 3 meanings per register decoded.
`ifndef URSEL_MAP_VH
`define URSEL_MAP_VH
`define URSEL_A_HOLD      4'h0
`define URSEL_A_INTEN     4'h1
`define URSEL_A_IDENT     4'h2
`define URSEL_A_LINECTL   4'h3
`define URSEL_A_MODEMCTL  4'h4
`define URSEL_A_LINESTAT  4'h5
`define URSEL_A_MODEMSTAT 4'h6
`define URSEL_A_SCRATCH   4'h7
`define URSEL_A_TXLV      4'h8
`define URSEL_A_RXLV      4'h9
`define URSEL_A_EXTRA     4'hF
`define URSEL_A_DLO       4'h0
`define URSEL_A_DHI       4'h1
`define URSEL_A_ENHFEAT   4'h2
`define URSEL_A_RES1      4'h4
`define URSEL_A_RES2      4'h5
`define URSEL_A_PAU1      4'h6
`define URSEL_A_PAU2      4'h7
`define URSEL_A_FLOWTHR   4'h6
`define URSEL_A_TRIGLVL   4'h7
`define URSEL_ENH_KEY     8'hBF
`define URSEL_LINE_DIVSEL 7
`define URSEL_ENH_FUNC    4
`define URSEL_MODEM_BANK  2
`define URSEL_MODEM_PRESC 7
`define URSEL_RST_LINE    8'h1D
`define URSEL_RST_ZERO    8'h00
`endif

/* File: design/ursel_reg8.v */
// One byte-wide host register with a write strobe and a per-bit write mask.
`timescale 1ns/100ps
`default_nettype none
module ursel_reg8 #(
  parameter [7:0] RST = 8'h00
) (
  input  wire       clk,   // Core clock.
  input  wire       rst_n, // Asynchronous reset, active low.
  input  wire       we,    // Write strobe.
  input  wire [7:0] mask,  // Bits allowed to change.
  input  wire [7:0] wd,    // Write data.
  output reg  [7:0] q      // Stored value.
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else if (we) begin
      q <= (q & ~mask) | (wd & mask);
    end
  end
endmodule // ursel_reg8
`default_nettype wire

/* File: design/ursel_rdreg.v */
// Registered read-data stage so that host read data come from a flip-flop.
`timescale 1ns/100ps
`default_nettype none
module ursel_rdreg #(
  parameter W = 8
) (
  input  wire         clk,   // Core clock.
  input  wire         rst_n, // Asynchronous reset, active low.
  input  wire         en,    // Capture enable.
  input  wire [W-1:0] d,     // Selected read value.
  output reg  [W-1:0] q      // Registered read data.
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {W{1'b0}};
    end else if (en) begin
      q <= d;
    end
  end
endmodule // ursel_rdreg
`default_nettype wire

/* File: design/ursel_bank.v */
// Register selection, banking and access gating for the UART host port.
`timescale 1ns/100ps
`default_nettype none
`include "ursel_map.vh"
module ursel_bank (
  input  wire       clk,            // Core clock, 100 MHz.
  input  wire       rst_n,          // Asynchronous reset, active low.
  input  wire       host_wr,        // Host write strobe, one cycle.
  input  wire       host_rd,        // Host read strobe, one cycle.
  input  wire [3:0] host_addr,      // Register slot address.
  input  wire [7:0] host_wdata,     // Host write data.
  output wire [7:0] host_rdata,     // Read data, registered, valid cycle after strobe.
  input  wire [7:0] rx_data,        // Oldest received character.
  output reg        rx_pop,         // Pops the receive FIFO on a holding read.
  output reg  [7:0] tx_data,        // Character loaded into the transmit FIFO.
  output reg        tx_push,        // Transmit FIFO push, one cycle.
  input  wire [7:0] ident_in,       // Interrupt identification from the core.
  input  wire [7:0] line_status_in, // Line status from the core.
  input  wire [7:0] modem_status_in,// Modem status from the core.
  input  wire [6:0] tx_level,       // Transmit FIFO free spaces.
  input  wire [6:0] rx_level,       // Received characters waiting.
  output reg  [7:0] fifo_control,   // Last FIFO control value written.
  output reg        fifo_ctl_wr,    // FIFO control written, one cycle.
  output wire [7:0] interrupt_enable,     // Interrupt enable register.
  output wire [7:0] line_control,         // Line control register.
  output wire [7:0] modem_control,        // Modem control register.
  output wire [7:0] extra_features,       // Extra features register.
  output wire [15:0] baud_divisor,        // Baud divisor, high and low bytes.
  output wire [7:0] enhanced_feature_reg, // Enhanced feature register.
  output wire [7:0] resume_char_1,        // First resume character.
  output wire [7:0] resume_char_2,        // Second resume character.
  output wire [7:0] pause_char_1,         // First pause character.
  output wire [7:0] pause_char_2,         // Second pause character.
  output wire [7:0] transmission_control, // Flow thresholds.
  output wire [7:0] trigger_level,        // FIFO trigger levels.
  output reg        rx_data_irq_en, // Receive data available interrupt enabled.
  output reg        modem_irq_en,   // Modem status interrupt enabled.
  output reg        fifo_enable,    // FIFOs enabled.
  output reg        irq_none,       // Identification status bit, high means none pending.
  output reg  [1:0] irq_prio_low,   // Identification priority code bits 1 and 3.
  output reg  [1:0] word_length,    // Word length select.
  output reg        parity_enable,  // Parity enabled.
  output reg        rx_fifo_reset   // Receive FIFO reset request, one cycle.
);
  localparam NREG = 14;
  localparam I_INTEN = 0, I_LINE = 1, I_MODEM = 2, I_SCR = 3, I_EFC = 4, I_DLO = 5, I_DHI = 6;
  localparam I_ENH = 7, I_RS1 = 8, I_RS2 = 9, I_PA1 = 10, I_PA2 = 11, I_FTH = 12, I_TRG = 13;

  reg  [NREG-1:0]   we;
  wire [7:0]        scratchpad;
  reg  [7:0]        next_rdata;
  wire [7:0]        modem_mask;

  wire bank_div = line_control[`URSEL_LINE_DIVSEL] &&
                  (line_control != `URSEL_ENH_KEY);
  wire bank_enh = (line_control == `URSEL_ENH_KEY);
  wire bank_fc  = enhanced_feature_reg[`URSEL_ENH_FUNC] &&
                  modem_control[`URSEL_MODEM_BANK] && !bank_div && !bank_enh;
  wire bank_gen = !bank_div && !bank_enh;

  // The prescaler bit is masked off, not the whole register, so other bits still update.
  assign modem_mask = enhanced_feature_reg[`URSEL_ENH_FUNC] ? 8'hFF : 8'h7F;

  // Only slots whose access condition holds produce a write strobe; all others are dropped.
  always @* begin
    we = {NREG{1'b0}};
    if (host_wr) begin
      if (bank_div) begin
        we[I_DLO] = (host_addr == `URSEL_A_DLO);
        we[I_DHI] = (host_addr == `URSEL_A_DHI);
      end
      if (bank_enh) begin
        we[I_ENH] = (host_addr == `URSEL_A_ENHFEAT);
        we[I_RS1] = (host_addr == `URSEL_A_RES1);
        we[I_RS2] = (host_addr == `URSEL_A_RES2);
        we[I_PA1] = (host_addr == `URSEL_A_PAU1);
        we[I_PA2] = (host_addr == `URSEL_A_PAU2);
      end
      if (bank_fc) begin
        we[I_FTH] = (host_addr == `URSEL_A_FLOWTHR);
        we[I_TRG] = (host_addr == `URSEL_A_TRIGLVL);
      end
      // Line control stays writable in every bank so software can always leave one.
      we[I_LINE]  = (host_addr == `URSEL_A_LINECTL);
      we[I_INTEN] = bank_gen && (host_addr == `URSEL_A_INTEN);
      we[I_MODEM] = !bank_enh && (host_addr == `URSEL_A_MODEMCTL);
      we[I_SCR]   = bank_gen && !bank_fc && (host_addr == `URSEL_A_SCRATCH);
      we[I_EFC]   = bank_gen && (host_addr == `URSEL_A_EXTRA);
    end
  end

  // One byte register per writable slot except holding and FIFO control; only modem control takes a partial mask.
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_inten (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_INTEN]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (interrupt_enable)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_LINE)
  ) u_line (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_LINE]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (line_control)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_modem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_MODEM]),
    .mask  (modem_mask),
    .wd    (host_wdata),
    .q     (modem_control)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_scratch (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_SCR]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (scratchpad)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_extra (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_EFC]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (extra_features)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_div_lo (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_DLO]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (baud_divisor[7:0])
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_div_hi (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_DHI]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (baud_divisor[15:8])
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_enh (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_ENH]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (enhanced_feature_reg)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_res1 (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_RS1]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (resume_char_1)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_res2 (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_RS2]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (resume_char_2)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_pau1 (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_PA1]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (pause_char_1)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_pau2 (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_PA2]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (pause_char_2)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_flow (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_FTH]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (transmission_control)
  );
  ursel_reg8 #(
    .RST (`URSEL_RST_ZERO)
  ) u_trig (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (we[I_TRG]),
    .mask  (8'hFF),
    .wd    (host_wdata),
    .q     (trigger_level)
  );

  wire gen_wr = host_wr && bank_gen;

  // Holding and FIFO control slot strobes toward the core.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_push      <= 1'b0;
      tx_data      <= 8'h00;
      rx_pop       <= 1'b0;
      fifo_control <= 8'h00;
      fifo_ctl_wr  <= 1'b0;
    end else begin
      tx_push     <= gen_wr && (host_addr == `URSEL_A_HOLD);
      fifo_ctl_wr <= gen_wr && (host_addr == `URSEL_A_IDENT);
      rx_pop      <= host_rd && bank_gen && (host_addr == `URSEL_A_HOLD);
      if (gen_wr && (host_addr == `URSEL_A_HOLD)) begin
        tx_data <= host_wdata;
      end
      if (gen_wr && (host_addr == `URSEL_A_IDENT)) begin
        fifo_control <= host_wdata;
      end
    end
  end

  // Read mux; the status inputs have no write path at all.
  always @* begin
    next_rdata = 8'h00;
    if (bank_div && host_addr == `URSEL_A_DLO) begin
      next_rdata = baud_divisor[7:0];
    end else if (bank_div && host_addr == `URSEL_A_DHI) begin
      next_rdata = baud_divisor[15:8];
    end else if (bank_enh && host_addr == `URSEL_A_ENHFEAT) begin
      next_rdata = enhanced_feature_reg;
    end else if (bank_enh && host_addr == `URSEL_A_RES1) begin
      next_rdata = resume_char_1;
    end else if (bank_enh && host_addr == `URSEL_A_RES2) begin
      next_rdata = resume_char_2;
    end else if (bank_enh && host_addr == `URSEL_A_PAU1) begin
      next_rdata = pause_char_1;
    end else if (bank_enh && host_addr == `URSEL_A_PAU2) begin
      next_rdata = pause_char_2;
    end else if (bank_fc && host_addr == `URSEL_A_FLOWTHR) begin
      next_rdata = transmission_control;
    end else if (bank_fc && host_addr == `URSEL_A_TRIGLVL) begin
      next_rdata = trigger_level;
    end else begin
      case (host_addr)
        `URSEL_A_HOLD: next_rdata = bank_gen ? rx_data : 8'h00;
        `URSEL_A_INTEN:     next_rdata = bank_gen ? interrupt_enable : 8'h00;
        `URSEL_A_IDENT:     next_rdata = bank_gen ? ident_in : 8'h00;
        `URSEL_A_LINECTL:   next_rdata = line_control;
        `URSEL_A_MODEMCTL:  next_rdata = bank_enh ? 8'h00 : modem_control;
        `URSEL_A_LINESTAT:  next_rdata = bank_gen ? line_status_in : 8'h00;
        `URSEL_A_MODEMSTAT: next_rdata = bank_gen ? modem_status_in : 8'h00;
        `URSEL_A_SCRATCH:   next_rdata = bank_gen ? scratchpad : 8'h00;
        `URSEL_A_TXLV:      next_rdata = bank_gen ? {1'b0, tx_level} : 8'h00;
        `URSEL_A_RXLV:      next_rdata = bank_gen ? {1'b0, rx_level} : 8'h00;
        `URSEL_A_EXTRA:     next_rdata = bank_gen ? extra_features : 8'h00;
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  ursel_rdreg #(
    .W (8)
  ) u_rd (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (host_rd),
    .d     (next_rdata),
    .q     (host_rdata)
  );

  // Low-bit decodes, registered so these outputs come from flip-flops.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_irq_en <= 1'b0;
      modem_irq_en   <= 1'b0;
      fifo_enable    <= 1'b0;
      irq_none       <= 1'b1;
      irq_prio_low   <= 2'b00;
      word_length    <= 2'b00;
      parity_enable  <= 1'b0;
      rx_fifo_reset  <= 1'b0;
    end else begin
      rx_data_irq_en <= interrupt_enable[0];
      fifo_enable    <= fifo_control[0];
      irq_none       <= ident_in[0];
      word_length    <= line_control[1:0];
      irq_prio_low   <= {ident_in[3], ident_in[1]};
      rx_fifo_reset  <= gen_wr && (host_addr == `URSEL_A_IDENT) && host_wdata[1];
      modem_irq_en   <= interrupt_enable[3];
      parity_enable  <= line_control[3];
    end
  end
endmodule // ursel_bank
`default_nettype wire

/* File: dv/ursel_core_model.sv */
// Receive side of the UART core that feeds characters to the bank.
`timescale 1ns/100ps
`default_nettype none
module ursel_core_model (
  input  wire logic       clk,      // Core clock.
  input  wire logic       rst_n,    // Reset, active low.
  input  wire logic       rx_pop,   // Pops the oldest character.
  output var  logic [7:0] rx_data,  // Oldest character.
  output var  logic [6:0] rx_level  // Characters waiting.
);
  // Each pop moves to a fresh character, so a stale read shows up as a mismatch.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data  <= 8'h41;
      rx_level <= 7'h40;
    end else if (rx_pop) begin
      rx_data  <= rx_data + 8'h01;
      rx_level <= rx_level - 7'h01;
    end
  end
endmodule // ursel_core_model
`default_nettype wire

/* File: dv/ursel_asserts.sv */
// Port assertions for the register selection bank.
`timescale 1ns/100ps
`default_nettype none
module ursel_asserts (
  input wire logic        clk,                  // Clock.
  input wire logic        rst_n,                // Reset.
  input wire logic        host_wr,              // Write.
  input wire logic        host_rd,              // Read.
  input wire logic [3:0]  host_addr,            // Slot.
  input wire logic [7:0]  host_wdata,           // Data.
  input wire logic [7:0]  host_rdata,           // Read data.
  input wire logic [7:0]  ident_in,             // Ident.
  input wire logic [7:0]  line_status_in,       // Status.
  input wire logic [7:0]  line_control,         // Control.
  input wire logic [7:0]  tx_data,              // Tx char.
  input wire logic        tx_push,              // Tx push.
  input wire logic [15:0] baud_divisor,         // Divisor.
  input wire logic [7:0]  enhanced_feature_reg, // Enhanced.
  input wire logic [7:0]  modem_control,        // Modem.
  input wire logic [7:0]  transmission_control, // Flow.
  input wire logic [1:0]  word_length,          // Length.
  input wire logic        parity_enable,        // Parity.
  input wire logic [1:0]  irq_prio_low          // Priority.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire gen = !line_control[7];
  a_hold_write: assert property (
    host_wr && host_addr == 4'h0 && gen |=> tx_push && tx_data == $past(host_wdata))
    else $error("Transmit load missing.");
  a_hold_gate: assert property (
    host_wr && host_addr == 4'h0 && !gen |=> !tx_push) else $error("Stray transmit push.");
  a_ident_slot: assert property (
    host_rd && host_addr == 4'h2 && gen |=> host_rdata == $past(ident_in))
    else $error("Ident read wrong.");
  a_status_read: assert property (
    host_rd && host_addr == 4'h5 && gen |=> host_rdata == $past(line_status_in))
    else $error("Status read wrong.");
  a_divisor_low: assert property (
    host_wr && host_addr == 4'h0 && !gen && line_control != 8'hBF
    |=> baud_divisor[7:0] == $past(host_wdata)) else $error("Divisor low not written.");
  a_efr_gate: assert property (
    line_control != 8'hBF |=> $stable(enhanced_feature_reg)) else $error("Enhanced changed.");
  a_presc_lock: assert property (
    !enhanced_feature_reg[4] |=> $stable(modem_control[7])) else $error("Prescaler changed.");
  a_flow_gate: assert property (
    !(enhanced_feature_reg[4] && modem_control[2]) |=> $stable(transmission_control))
    else $error("Flow register changed.");
  a_field_copy: assert property (
    rst_n |=> {word_length, parity_enable, irq_prio_low} == {$past(line_control[1:0]),
    $past(line_control[3]), $past(ident_in[3]), $past(ident_in[1])})
    else $error("Decoded bits wrong.");
endmodule // ursel_asserts
bind ursel_bank ursel_asserts chk_i (.*);
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the register selection bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, host_wr = 0, host_rd = 0;
  logic [3:0] host_addr = 0;
  logic [7:0] host_wdata = 0, ident_in = 0, line_status_in = 0, modem_status_in = 0;
  logic [6:0] tx_level = 0, rx_level;
  logic [7:0] rx_data, host_rdata, tx_data, fifo_control, interrupt_enable, line_control;
  logic [7:0] modem_control, extra_features, enhanced_feature_reg, resume_char_1;
  logic [7:0] resume_char_2, pause_char_1, pause_char_2, transmission_control, trigger_level;
  logic [15:0] baud_divisor, r = 16'h91ED;
  logic [1:0] irq_prio_low, word_length;
  logic rx_pop, tx_push, fifo_ctl_wr, rx_data_irq_en, modem_irq_en, fifo_enable;
  logic irq_none, parity_enable, rx_fifo_reset;
  logic [7:0] v, w, f, exp_rx = 8'h41;
  int num_errors = 0, check_count = 0;
  always #5 clk = ~clk;
  ursel_bank dut (.*);
  ursel_core_model core (.*);
  function automatic [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Each access leaves one idle cycle so a strobe is never set twice in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    #1 chk(n, {8'h00, e}, {8'h00, host_rdata});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk("line_ctl", 16'h001D, {8'h00, line_control});
    for (int i = 0; i < 8; i++) begin
      r = nx(r);
      v = r[7:0];
      w = r[15:8];
      f = {v[7:2], i[0], 1'b1};
      @(posedge clk);
      line_status_in <= v;
      modem_status_in <= w;
      ident_in <= v ^ w;
      tx_level <= w[6:0];
      wr(4'h7, v);
      rd(4'h7, v, "scratch");
      wr(4'h1, w);
      wr(4'h0, v);
      chk("txd", {7'h00, 1'b1, v}, {7'h00, tx_push, tx_data});
      rd(4'h0, exp_rx, "rx_hold");
      exp_rx++;
      rd(4'h2, v ^ w, "ident");
      wr(4'h2, f);
      chk("fifo_ctl", {7'h01, f[1], f},
          {6'h00, fifo_ctl_wr, rx_fifo_reset, fifo_control});
      for (int j = 5; j < 10; j++) if (j != 7) wr(j[3:0], ~v);
      rd(4'h5, v, "line_stat");
      rd(4'h6, w, "modem_stat");
      rd(4'h8, {1'b0, w[6:0]}, "txl");
      rd(4'h9, 8'h81 - exp_rx, "rxl");
      rd(4'h7, v, "scratch_kept");
      wr(4'hF, w);
      wr(4'h3, {1'b0, v[6:0]});
      @(posedge clk);
      #1 chk("ext", {w, w}, {extra_features, interrupt_enable});
      chk("bit0", {4'h0, w[0], f[0], v[0] ^ w[0], v[0]},
          {4'h0, rx_data_irq_en, fifo_enable, irq_none, word_length[0]});
      chk("bit13", {v[1], v[3] ^ w[3], v[1] ^ w[1], w[3], v[3]},
          {word_length[1], irq_prio_low, modem_irq_en, parity_enable});
    end
    chk("enh_feat", 16'h0000, {8'h00, enhanced_feature_reg});
    wr(4'h4, 8'h84);
    wr(4'h6, v);
    chk("modem_ctl", 16'h0400, {modem_control, transmission_control});
    wr(4'h3, 8'h80);
    wr(4'h0, v);
    wr(4'h1, w);
    chk("div", {w, v}, baud_divisor);
    rd(4'h0, v, "div_lo");
    rd(4'h1, w, "div_hi");
    rd(4'h5, 8'h00, "stat_hidden");
    wr(4'h3, 8'hBF);
    wr(4'h2, 8'h10);
    for (int j = 4; j < 8; j++) wr(j[3:0], v + j[7:0]);
    chk("res", {v + 8'h04, v + 8'h05}, {resume_char_1, resume_char_2});
    chk("pau", {v + 8'h06, v + 8'h07}, {pause_char_1, pause_char_2});
    rd(4'h2, 8'h10, "enh_rd");
    rd(4'h6, v + 8'h06, "pause_rd");
    wr(4'h3, 8'h03);
    wr(4'h4, 8'h84);
    wr(4'h6, w);
    wr(4'h7, v);
    chk("flow", {w, v}, {transmission_control, trigger_level});
    chk("presc", 16'h0084, {8'h00, modem_control});
    rd(4'h6, w, "flow_rd");
    final_report;
  end
endmodule // testbench
`default_nettype wire
